// *** csp_pkg.sv ***
// Shared constants for the card socket status and power register bank.
// Assumes a byte-wide register port in the socket's memory space.
`default_nettype none

package csp_pkg;

	// Register offsets within the socket space
	localparam logic [11:0] CSP_OFF_IDENT = 12'h0800;
	localparam logic [11:0] CSP_OFF_STATUS = 12'h0801;
	localparam logic [11:0] CSP_OFF_POWER = 12'h0802;

	// Identification register fields
	localparam logic [1:0] CSP_INTERFACE_KIND_CODE = 2'h2;
	localparam int CSP_ID_KIND_LSB = 6;
	localparam int CSP_ID_SPARE_LSB = 4;
	localparam int CSP_ID_REV_LSB = 0;
	localparam logic [1:0] CSP_ID_SPARE_RESET = 2'h0;

	// Power control register fields
	localparam int CSP_PC_OUT_EN = 7;
	localparam int CSP_PC_AUTO_SW = 5;
	localparam int CSP_PC_SUPPLY_EN = 4;
	localparam int CSP_PC_VCC_LSB = 3;
	localparam int CSP_PC_VPP_LSB = 0;
	localparam logic [7:0] CSP_POWER_RESET = 8'h00;

	// Supply and programming voltage request codes
	localparam logic [1:0] CSP_VCC_5V = 2'h2;
	localparam logic [1:0] CSP_VCC_3V3 = 2'h3;
	localparam logic [1:0] CSP_VPP_NONE = 2'h0;
	localparam logic [1:0] CSP_VPP_VCC = 2'h1;
	localparam logic [1:0] CSP_VPP_12V = 2'h2;

	// Interface status register fields
	localparam int CSP_ST_POWER = 6;
	localparam int CSP_ST_READY = 5;
	localparam int CSP_ST_WP = 4;
	localparam int CSP_ST_CD_B = 3;
	localparam int CSP_ST_CD_A = 2;
	localparam int CSP_ST_PIN_LSB = 0;

	// Reset values of the synchronisers and the read data
	localparam logic [3:0] CSP_PIN_RESET = 4'h0;
	localparam logic [1:0] CSP_DETECT_IDLE = 2'h3;
	localparam logic [7:0] CSP_RDATA_RESET = 8'h00;

	// Unmapped reads return this
	localparam logic [7:0] CSP_UNMAPPED_DATA = 8'h00;

endpackage

`default_nettype wire

// *** csp_socket_regs.sv ***
// Socket identification, interface status and power control registers.
// Assumes a same-clock host register port; card pins arrive asynchronously.
// Supply and output enable drives go to external switches and buffers.
`default_nettype none

module csp_socket_regs
	import csp_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter logic [3:0] REV_RESET = 4'h3, // Arbitrary revision value
	parameter logic [3:0] OLD_MODEL_REV = 4'h1 // Arbitrary older-model value
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	input wire logic ident_write_enable_in,
	input wire logic supply_level_select_in,
	input wire logic card_ready_in,
	input wire logic card_write_protect_in,
	input wire logic card_detect_a_n_in,
	input wire logic card_detect_b_n_in,
	input wire logic battery_detect_a_in,
	input wire logic battery_detect_b_in,
	output logic card_outputs_enable_out,
	output logic socket_power_on_out,
	output logic supply_5v_on_out,
	output logic supply_3v3_on_out,
	output logic program_vcc_on_out,
	output logic program_12v_on_out
);

	// Refuse address widths that cannot reach the socket offsets
	if (ADDR_W < 12) begin : g_bad_addr_w
		$error("ADDR_W must be at least 12");
	end

	// Register fields
	logic [1:0] ident_spare_q;
	logic [3:0] register_model_revision_q;
	logic card_outputs_enable_q;
	logic auto_power_switch_enable_q;
	logic card_supply_enable_q;
	logic [1:0] supply_voltage_request_q;
	logic [1:0] program_voltage_request_q;
	// Synchroniser stages: ready, write protect, battery b and a; detects b and a
	logic [3:0] pin_meta_q;
	logic [3:0] pin_sync_q;
	logic [1:0] detect_meta_q;
	logic [1:0] detect_sync_q;
	// Decoded strobes and derived socket state
	logic ident_wr;
	logic power_wr;
	logic older_model;
	logic card_present;
	logic supply_on_d;
	logic level_5v_d;
	logic level_3v3_d;
	logic program_vcc_d;
	logic program_12v_d;
	// Read images
	logic [7:0] ident_rd;
	logic [7:0] status_rd;
	logic [7:0] power_rd;
	logic [7:0] rdata_d;

	// Address compare on the full port width
	function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [11:0] off);
		hit = (addr == ADDR_W'(off));
	endfunction

	// Newer-model supply code to {5 V, 3.3 V}; both low codes mean off
	function automatic logic [1:0] vcc_levels(input logic [1:0] code);
		vcc_levels = {(code == CSP_VCC_5V), (code == CSP_VCC_3V3)};
	endfunction

	// Programming voltage select; a request only counts while the supply is on
	function automatic logic vpp_select(input logic supply_on, input logic [1:0] code,
		input logic [1:0] want);
		vpp_select = supply_on && (code == want);
	endfunction

	// Older layout: bit 6 and bits 3-2 always read zero
	function automatic logic [7:0] older_power_image(input logic out_en, input logic auto_sw,
		input logic supply_en, input logic [1:0] vpp);
		older_power_image = 8'h00;
		older_power_image[CSP_PC_OUT_EN] = out_en;
		older_power_image[CSP_PC_AUTO_SW] = auto_sw;
		older_power_image[CSP_PC_SUPPLY_EN] = supply_en;
		older_power_image[CSP_PC_VPP_LSB +: 2] = vpp;
	endfunction

	// Newer layout: bits 6-5 and bit 2 always read zero
	function automatic logic [7:0] newer_power_image(input logic out_en, input logic [1:0] vcc,
		input logic [1:0] vpp);
		newer_power_image = 8'h00;
		newer_power_image[CSP_PC_OUT_EN] = out_en;
		newer_power_image[CSP_PC_VCC_LSB +: 2] = vcc;
		newer_power_image[CSP_PC_VPP_LSB +: 2] = vpp;
	endfunction

	// Two-stage synchroniser for the card status pins
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_meta_q <= CSP_PIN_RESET;
			pin_sync_q <= CSP_PIN_RESET;
		end else begin
			pin_meta_q <= {card_ready_in, card_write_protect_in,
				battery_detect_b_in, battery_detect_a_in};
			pin_sync_q <= pin_meta_q;
		end
	end

	// Detect synchroniser resets to an empty socket, so no phantom card powers up
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			detect_meta_q <= CSP_DETECT_IDLE;
			detect_sync_q <= CSP_DETECT_IDLE;
		end else begin
			detect_meta_q <= {card_detect_b_n_in, card_detect_a_n_in};
			detect_sync_q <= detect_meta_q;
		end
	end

	// Write strobes per register; the ident one also needs the write enable
	assign ident_wr = reg_wr_in && ident_write_enable_in && hit(reg_addr_in, CSP_OFF_IDENT);
	assign power_wr = reg_wr_in && hit(reg_addr_in, CSP_OFF_POWER);

	// Identification register writes, gated by the write enable
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ident_spare_q <= CSP_ID_SPARE_RESET;
			register_model_revision_q <= REV_RESET;
		end else if (ident_wr) begin
			ident_spare_q <= reg_wdata_in[CSP_ID_SPARE_LSB +: 2];
			register_model_revision_q <= reg_wdata_in[CSP_ID_REV_LSB +: 4];
		end
	end

	// Model select from the revision field
	assign older_model = (register_model_revision_q == OLD_MODEL_REV);

	// Output enable and programming request exist in both layouts
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			card_outputs_enable_q <= CSP_POWER_RESET[CSP_PC_OUT_EN];
			program_voltage_request_q <= CSP_POWER_RESET[CSP_PC_VPP_LSB +: 2];
		end else if (power_wr) begin
			card_outputs_enable_q <= reg_wdata_in[CSP_PC_OUT_EN];
			program_voltage_request_q <= reg_wdata_in[CSP_PC_VPP_LSB +: 2];
		end
	end

	// Older-layout fields; they keep their values while the newer layout is active
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			auto_power_switch_enable_q <= CSP_POWER_RESET[CSP_PC_AUTO_SW];
			card_supply_enable_q <= CSP_POWER_RESET[CSP_PC_SUPPLY_EN];
		end else if (power_wr && older_model) begin
			auto_power_switch_enable_q <= reg_wdata_in[CSP_PC_AUTO_SW];
			card_supply_enable_q <= reg_wdata_in[CSP_PC_SUPPLY_EN];
		end
	end

	// Newer-layout supply request; untouched by writes in the older layout
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			supply_voltage_request_q <= CSP_POWER_RESET[CSP_PC_VCC_LSB +: 2];
		end else if (power_wr && !older_model) begin
			supply_voltage_request_q <= reg_wdata_in[CSP_PC_VCC_LSB +: 2];
		end
	end

	// Both detects low means the card is seated
	assign card_present = !detect_sync_q[0] && !detect_sync_q[1];

	// Supply state and level for each model, then the programming voltage
	always_comb begin
		if (older_model) begin
			supply_on_d = card_supply_enable_q && (!auto_power_switch_enable_q || card_present);
			level_5v_d = supply_on_d && !supply_level_select_in;
			level_3v3_d = supply_on_d && supply_level_select_in;
		end else begin
			{level_5v_d, level_3v3_d} = vcc_levels(supply_voltage_request_q);
			supply_on_d = level_5v_d || level_3v3_d;
		end
		program_vcc_d = vpp_select(supply_on_d, program_voltage_request_q, CSP_VPP_VCC);
		program_12v_d = vpp_select(supply_on_d, program_voltage_request_q, CSP_VPP_12V);
	end

	// Card interface output enable, one flop behind the register bit
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			card_outputs_enable_out <= 1'b0;
		end else begin
			card_outputs_enable_out <= card_outputs_enable_q;
		end
	end

	// Supply switch drives
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			socket_power_on_out <= 1'b0;
			supply_5v_on_out <= 1'b0;
			supply_3v3_on_out <= 1'b0;
		end else begin
			socket_power_on_out <= supply_on_d;
			supply_5v_on_out <= level_5v_d;
			supply_3v3_on_out <= level_3v3_d;
		end
	end

	// Programming voltage drives, held off while the supply is off
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			program_vcc_on_out <= 1'b0;
			program_12v_on_out <= 1'b0;
		end else begin
			program_vcc_on_out <= program_vcc_d;
			program_12v_on_out <= program_12v_d;
		end
	end

	// Identification image: fixed kind code over the software fields
	always_comb begin
		ident_rd = 8'h00;
		ident_rd[CSP_ID_KIND_LSB +: 2] = CSP_INTERFACE_KIND_CODE;
		ident_rd[CSP_ID_SPARE_LSB +: 2] = ident_spare_q;
		ident_rd[CSP_ID_REV_LSB +: 4] = register_model_revision_q;
	end

	// Status image: bit 7 stays zero, bit 6 is the socket power drive, the rest follow the synchronised pins
	// Bits 1-0 carry battery detects, or speaker and status change on the same pins
	always_comb begin
		status_rd = 8'h00;
		status_rd[CSP_ST_POWER] = socket_power_on_out;
		status_rd[CSP_ST_READY] = pin_sync_q[3];
		status_rd[CSP_ST_WP] = pin_sync_q[2];
		status_rd[CSP_ST_CD_B] = !detect_sync_q[1];
		status_rd[CSP_ST_CD_A] = !detect_sync_q[0];
		status_rd[CSP_ST_PIN_LSB +: 2] = pin_sync_q[1:0];
	end

	// Power image follows the active layout
	assign power_rd = older_model ?
		older_power_image(card_outputs_enable_q, auto_power_switch_enable_q, card_supply_enable_q,
			program_voltage_request_q) :
		newer_power_image(card_outputs_enable_q, supply_voltage_request_q, program_voltage_request_q);

	// Read decode; a read in the same cycle as a write returns the old value
	always_comb begin
		if (hit(reg_addr_in, CSP_OFF_IDENT)) begin
			rdata_d = ident_rd;
		end else if (hit(reg_addr_in, CSP_OFF_STATUS)) begin
			rdata_d = status_rd;
		end else if (hit(reg_addr_in, CSP_OFF_POWER)) begin
			rdata_d = power_rd;
		end else begin
			rdata_d = CSP_UNMAPPED_DATA;
		end
	end

	// Read valid pulse, one cycle after the strobe
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_rd_in;
		end
	end

	// Read data, held until the next read
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= CSP_RDATA_RESET;
		end else if (reg_rd_in) begin
			reg_rdata_out <= rdata_d;
		end
	end

endmodule

`default_nettype wire

// *** csp_socket_regs_monitor.sv ***
// Checker for the socket register bank, watching its ports only.
// Assumes one clock and the active-low asynchronous reset.
`default_nettype none
module csp_socket_regs_monitor
	import csp_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic reg_rvalid_out,
	input wire logic card_outputs_enable_out,
	input wire logic socket_power_on_out,
	input wire logic supply_5v_on_out,
	input wire logic supply_3v3_on_out,
	input wire logic program_vcc_on_out,
	input wire logic program_12v_on_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	// Read answers and register contents
	chk_kind_code: assert property (reg_rd_in && reg_addr_in == ADDR_W'(CSP_OFF_IDENT)
		|=> reg_rdata_out[7:6] == CSP_INTERFACE_KIND_CODE) else $error("kind code wrong");
	chk_status_top: assert property (reg_rd_in && reg_addr_in == ADDR_W'(CSP_OFF_STATUS)
		|=> reg_rvalid_out && !reg_rdata_out[7]) else $error("status bit 7 set");
	chk_status_power: assert property (reg_rd_in && reg_addr_in == ADDR_W'(CSP_OFF_STATUS)
		|=> reg_rdata_out[6] == $past(socket_power_on_out)) else $error("power status wrong");
	chk_power_reserved: assert property (reg_rd_in && reg_addr_in == ADDR_W'(CSP_OFF_POWER)
		|=> reg_rdata_out[6] == 1'b0 && reg_rdata_out[2] == 1'b0) else $error("reserved power bit set");
	chk_rvalid_pulse: assert property (!reg_rd_in |=> !reg_rvalid_out) else $error("stray read valid");
	// Socket outputs
	chk_outputs_enable: assert property (reg_wr_in && reg_addr_in == ADDR_W'(CSP_OFF_POWER)
		|=> ##1 card_outputs_enable_out == $past(reg_wdata_in[7], 2)) else $error("output enable wrong");
	chk_vpp_gated: assert property (program_vcc_on_out || program_12v_on_out |-> socket_power_on_out
		&& !(program_vcc_on_out && program_12v_on_out)) else $error("vpp without supply");
	chk_supply_level: assert property ($onehot0({supply_5v_on_out, supply_3v3_on_out})
		&& socket_power_on_out == (supply_5v_on_out || supply_3v3_on_out)) else $error("supply level wrong");
	cover property (reg_wr_in && reg_addr_in == ADDR_W'(CSP_OFF_POWER));
	cover property (socket_power_on_out && program_12v_on_out);
	cover property ($fell(socket_power_on_out));
endmodule
bind csp_socket_regs csp_socket_regs_monitor #(.ADDR_W(ADDR_W)) csp_socket_regs_monitor_i (
	.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
	.reg_rvalid_out(reg_rvalid_out), .card_outputs_enable_out(card_outputs_enable_out),
	.socket_power_on_out(socket_power_on_out), .supply_5v_on_out(supply_5v_on_out),
	.supply_3v3_on_out(supply_3v3_on_out), .program_vcc_on_out(program_vcc_on_out),
	.program_12v_on_out(program_12v_on_out));
`default_nettype wire

// *** csp_card_model.sv ***
// Card model driving the socket's card status pins.
// Assumes the bench sets insertion and the wanted pin levels.
`default_nettype none
module csp_card_model (
	input wire logic inserted_in,
	input wire logic ready_in,
	input wire logic wp_in,
	input wire logic [1:0] bvd_in,
	output logic ready_out,
	output logic wp_out,
	output logic cd_a_n_out,
	output logic cd_b_n_out,
	output logic [1:0] bvd_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// Detects pulled high when empty; floating pins show inverted levels
	assign cd_a_n_out = !inserted_in;
	assign cd_b_n_out = !inserted_in;
	assign ready_out = inserted_in ? ready_in : !ready_in;
	assign wp_out = inserted_in ? wp_in : !wp_in;
	assign bvd_out = inserted_in ? bvd_in : ~bvd_in;
endmodule
`default_nettype wire

// *** csp_socket_regs_bench.sv ***
// Testbench for the socket register bank with a card model.
// Drives the register port at the falling clock edge.
`default_nettype none
module csp_socket_regs_bench
	import csp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [3:0] REV = 4'h3;
	localparam logic [3:0] OLD = 4'h1;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, we = 0, lvl = 0, ins = 1, rdy = 1, wp = 0;
	logic [11:0] addr = 0;
	logic [7:0] wdat = 0, got, rdata;
	logic [1:0] bvd = 2'h3, bp;
	logic rv, oe, pwr, v5, v33, pvcc, p12, pr, pw, ca, cb;
	int failures = 0, n_tests = 0;
	always #10 clk = ~clk;
	csp_card_model csp_card_model_i (.inserted_in(ins), .ready_in(rdy), .wp_in(wp), .bvd_in(bvd),
		.ready_out(pr), .wp_out(pw), .cd_a_n_out(ca), .cd_b_n_out(cb), .bvd_out(bp));
	csp_socket_regs #(.REV_RESET(REV), .OLD_MODEL_REV(OLD)) csp_socket_regs_i (.clk_sys_in(clk),
		.rst_n_in(rst_n), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdat),
		.reg_rdata_out(rdata), .reg_rvalid_out(rv), .ident_write_enable_in(we), .supply_level_select_in(lvl),
		.card_ready_in(pr), .card_write_protect_in(pw), .card_detect_a_n_in(ca), .card_detect_b_n_in(cb),
		.battery_detect_a_in(bp[0]), .battery_detect_b_in(bp[1]), .card_outputs_enable_out(oe),
		.socket_power_on_out(pwr), .supply_5v_on_out(v5), .supply_3v3_on_out(v33),
		.program_vcc_on_out(pvcc), .program_12v_on_out(p12));
	task automatic chk(input logic [7:0] exp, input logic [7:0] val);
		n_tests++;
		if (val !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, val, exp);
		end
	endtask
	// One single-cycle access; read data taken in the middle of the answer cycle, while valid is high
	task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(negedge clk);
		wr = w;
		rd = !w;
		addr = a;
		wdat = d;
		@(negedge clk);
		wr = 0;
		rd = 0;
		got = rdata;
	endtask
	task automatic rc(input logic [11:0] a, input logic [7:0] exp);
		acc(0, a, 8'h00);
		chk(exp, got);
		chk(8'h01, {7'h00, rv});
	endtask
	// Socket outputs once synchroniser and output flops settle
	task automatic outs(input logic [7:0] exp);
		repeat (4) @(negedge clk);
		chk(exp, {2'h0, oe, pwr, v5, v33, pvcc, p12});
	endtask
	function automatic logic [7:0] st(input logic p);
		return {1'b0, p, rdy, wp, ins, ins, bvd};
	endfunction
	task automatic wrap_up();
		$display("failures %0d n_tests %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#200000;
		failures++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge clk);
		@(negedge clk);
		rst_n = 1;
		rc(CSP_OFF_IDENT, {2'h2, 2'h0, REV});
		rc(CSP_OFF_POWER, 8'h00);
		rc(CSP_OFF_STATUS, st(0));
		acc(1, CSP_OFF_IDENT, 8'h35);
		rc(CSP_OFF_IDENT, {2'h2, 2'h0, REV});
		we = 1;
		acc(1, CSP_OFF_IDENT, {2'h0, 2'h3, REV});
		rc(CSP_OFF_IDENT, {2'h2, 2'h3, REV});
		acc(1, CSP_OFF_POWER, 8'hff);
		rc(CSP_OFF_POWER, 8'h9b);
		outs(8'h34);
		rc(CSP_OFF_STATUS, st(1));
		acc(1, CSP_OFF_POWER, 8'h92);
		outs(8'h39);
		acc(1, CSP_OFF_POWER, 8'h81);
		outs(8'h20);
		acc(1, CSP_OFF_POWER, 8'h89);
		rc(CSP_OFF_POWER, 8'h89);
		outs(8'h20);
		acc(1, CSP_OFF_STATUS, 8'hff);
		rc(CSP_OFF_STATUS, st(0));
		acc(1, CSP_OFF_IDENT, {2'h0, 2'h0, OLD});
		acc(1, CSP_OFF_POWER, 8'hff);
		rc(CSP_OFF_POWER, 8'hb3);
		outs(8'h38);
		ins = 0;
		outs(8'h20);
		lvl = 1;
		acc(1, CSP_OFF_POWER, 8'h91);
		outs(8'h36);
		ins = 1;
		for (int i = 0; i < 4; i++) begin
			bvd = 2'(i);
			rdy = i[0];
			wp = i[1];
			repeat (4) @(negedge clk);
			rc(CSP_OFF_STATUS, st(1));
		end
		acc(1, CSP_OFF_POWER, 8'h00);
		outs(8'h00);
		wrap_up();
	end
endmodule
`default_nettype wire
